/* design/osc_tick.sv */
`timescale 1ns/100ps
module osc_tick #(
  parameter int DIV = 125
) (
  input  wire logic clock_i,
  input  wire logic reset_i,
  output logic      tick_o
);

  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } tick_state_t;

  tick_state_t state;
  tick_state_t next_state;

  always_comb begin
    next_state      = state;
    next_state.tick = 1'b0;
    if (state.cnt == 16'(DIV - 1)) begin
      next_state.cnt  = 16'h0000;
      next_state.tick = 1'b1;
    end else begin
      next_state.cnt = state.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign tick_o = state.tick;

endmodule : osc_tick

/* design/reset_init_pkg.sv */
package reset_init_pkg;

  // ****************************************
  // Initial register values
  // ****************************************
  localparam logic [7:0]  PORT_LATCH_INIT    = 8'h00;
  localparam logic [7:0]  PORT_DIR_INIT      = 8'hff;
  localparam logic [7:0]  PULLUP_INIT        = 8'h00;
  localparam logic [7:0]  MEM_SIZE_INIT      = 8'hcf;
  localparam logic [7:0]  SETTLE_SEL_INIT    = 8'h05;
  localparam logic [7:0]  CLEAR8             = 8'h00;
  localparam logic [15:0] CLEAR16            = 16'h0000;
  localparam logic [7:0]  WDT_MODE_INIT      = 8'h67;
  localparam logic [7:0]  WDT_ENABLE_INIT    = 8'h9a;
  localparam logic [15:0] RESET_VECTOR_ADDR  = 16'h0000;

  // ****************************************
  // Timing
  // ****************************************
  localparam int          CLK_PERIOD_NS      = 8;
  localparam int          OSC_PERIOD_NS      = 1000;
  localparam int          OSC_DIV            = OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int          STOP_OSC_PERIODS   = 17;

  // ****************************************
  // Register map of the register bus
  // ****************************************
  localparam logic [7:0]  ADDR_PORT_LATCH    = 8'h00;
  localparam logic [7:0]  ADDR_PORT_TWO      = 8'h01;
  localparam logic [7:0]  ADDR_PORT_DIR      = 8'h02;
  localparam logic [7:0]  ADDR_PULLUP        = 8'h03;
  localparam logic [7:0]  ADDR_MEM_SIZE      = 8'h04;
  localparam logic [7:0]  ADDR_SETTLE_SEL    = 8'h05;
  localparam logic [7:0]  ADDR_SETTLE_STAT   = 8'h06;
  localparam logic [7:0]  ADDR_PROC_CLK      = 8'h07;
  localparam logic [7:0]  ADDR_INT_OSC       = 8'h08;
  localparam logic [7:0]  ADDR_MAIN_CLK      = 8'h09;
  localparam logic [7:0]  ADDR_MAIN_OSC      = 8'h0a;
  localparam logic [7:0]  ADDR_WIDE_CNT_LO   = 8'h10;
  localparam logic [7:0]  ADDR_WIDE_CNT_HI   = 8'h11;
  localparam logic [7:0]  ADDR_WIDE_CCA_LO   = 8'h12;
  localparam logic [7:0]  ADDR_WIDE_CCA_HI   = 8'h13;
  localparam logic [7:0]  ADDR_WIDE_CCB_LO   = 8'h14;
  localparam logic [7:0]  ADDR_WIDE_CCB_HI   = 8'h15;
  localparam logic [7:0]  ADDR_WIDE_CTRL0    = 8'h16;
  localparam logic [7:0]  ADDR_BYTE_BASE     = 8'h20;
  localparam logic [7:0]  ADDR_IVL_BASE      = 8'h30;
  localparam logic [7:0]  ADDR_CARRIER       = 8'h38;
  localparam logic [7:0]  ADDR_WDT_MODE      = 8'h40;
  localparam logic [7:0]  ADDR_WDT_ENABLE    = 8'h41;
  localparam logic [7:0]  ADDR_STATUS        = 8'h42;
  localparam logic [7:0]  ADDR_RAM_BASE      = 8'h80;

  typedef enum logic [1:0] {
    SEQ_RESET = 2'b00,
    SEQ_STOP  = 2'b01,
    SEQ_RUN   = 2'b10
  } seq_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

endpackage : reset_init_pkg

/* design/reset_state_initializer.sv */
`timescale 1ns/100ps
module reset_state_initializer #(
  parameter int RAM_WORDS = 16
) (
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  input  wire logic        ext_reset_n_i,
  input  wire logic        wdt_overflow_i,
  input  wire logic        clock_monitor_reset_i,
  input  wire logic        voltage_reset_i,
  input  wire logic        standby_i,
  input  wire logic [15:0] vector_data_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [7:0]       rdata_o,
  output logic [15:0]      vector_addr_o,
  output logic [15:0]      program_counter_o,
  output logic             cpu_run_o,
  output logic             internal_reset_o,
  output logic [7:0]       port_out_o,
  output logic [7:0]       port_oe_o,
  output logic             reset_indicator_pin_o,
  output logic             reset_indicator_pin_oe_o
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    reset_init_pkg::seq_state_t seq;
    logic [4:0]  stop_cnt;
    logic        int_reset;
    logic        pc_valid;
    logic [15:0] pc;
    logic [7:0]  port_latch;
    logic [7:0]  port_two_latch;
    logic [7:0]  port_direction_register;
    logic [7:0]  pullup_select_register;
    logic [7:0]  memory_size_select;
    logic [7:0]  osc_settle_time_select;
    logic [7:0]  osc_settle_counter_status;
    logic [7:0]  processor_clock_control;
    logic [7:0]  internal_osc_control;
    logic [7:0]  main_clock_select;
    logic [7:0]  main_osc_control;
    logic [15:0] wide_timer_counter;
    logic [15:0] wide_capture_compare_a;
    logic [15:0] wide_capture_compare_b;
    logic [31:0] wide_ctrl;
    logic [7:0]  byte_event_counter_a;
    logic [7:0]  byte_event_counter_b;
    logic [47:0] byte_ctrl;
    logic [31:0] ivl_ctrl;
    logic [7:0]  carrier_control;
    logic [7:0]  watchdog_mode_register;
    logic [7:0]  watchdog_enable_register;
    logic        ind_level;
    logic [7:0]  rdata;
  } init_state_t;

  init_state_t state;
  init_state_t next_state;
  logic [7:0]  ram [RAM_WORDS];
  logic        osc_tick;
  logic        any_reset;
  logic        wdt_self_reset;
  logic [7:0]  ram_rdata;
  logic [3:0]  ram_idx;

  // Divider restarts with every source, so the stop span is always whole periods
  osc_tick #(
    .DIV (reset_init_pkg::OSC_DIV)
  ) u_osc_tick (
    .clock_i (clock_i),
    .reset_i (any_reset),
    .tick_o  (osc_tick)
  );

  // Sources all treated alike; inputs are synchronous to clock_i
  assign any_reset      = reset_i | ~ext_reset_n_i | wdt_overflow_i
                        | clock_monitor_reset_i | voltage_reset_i;
  assign wdt_self_reset = wdt_overflow_i;
  assign ram_idx        = addr_i[3:0];
  assign ram_rdata      = ram[ram_idx];

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_state       = state;
    next_state.rdata = 8'h00;
    if (any_reset) begin
      next_state.seq                       = reset_init_pkg::SEQ_RESET;
      next_state.int_reset                 = 1'b1;
      next_state.stop_cnt                  = 5'h00;
      next_state.pc_valid                  = 1'b0;
      next_state.port_latch                = reset_init_pkg::PORT_LATCH_INIT;
      next_state.port_direction_register   = reset_init_pkg::PORT_DIR_INIT;
      next_state.pullup_select_register    = reset_init_pkg::PULLUP_INIT;
      next_state.memory_size_select        = reset_init_pkg::MEM_SIZE_INIT;
      next_state.osc_settle_time_select    = reset_init_pkg::SETTLE_SEL_INIT;
      next_state.osc_settle_counter_status = reset_init_pkg::CLEAR8;
      next_state.processor_clock_control   = reset_init_pkg::CLEAR8;
      next_state.internal_osc_control      = reset_init_pkg::CLEAR8;
      next_state.main_clock_select         = reset_init_pkg::CLEAR8;
      next_state.main_osc_control          = reset_init_pkg::CLEAR8;
      next_state.wide_timer_counter        = reset_init_pkg::CLEAR16;
      next_state.wide_capture_compare_a    = reset_init_pkg::CLEAR16;
      next_state.wide_capture_compare_b    = reset_init_pkg::CLEAR16;
      next_state.wide_ctrl                 = '0;
      next_state.byte_event_counter_a      = reset_init_pkg::CLEAR8;
      next_state.byte_event_counter_b      = reset_init_pkg::CLEAR8;
      next_state.byte_ctrl                 = '0;
      next_state.ivl_ctrl                  = '0;
      next_state.carrier_control           = reset_init_pkg::CLEAR8;
      next_state.watchdog_mode_register    = reset_init_pkg::WDT_MODE_INIT;
      next_state.watchdog_enable_register  = reset_init_pkg::WDT_ENABLE_INIT;
      // Port two latch is left as it was: undefined by design
    end else begin
      case (state.seq)
        reset_init_pkg::SEQ_RESET: begin
          next_state.seq      = reset_init_pkg::SEQ_STOP;
          next_state.stop_cnt = 5'h00;
        end
        reset_init_pkg::SEQ_STOP: begin
          if (osc_tick) begin
            if (state.stop_cnt == 5'(reset_init_pkg::STOP_OSC_PERIODS - 1)) begin
              next_state.seq       = reset_init_pkg::SEQ_RUN;
              next_state.int_reset = 1'b0;
              next_state.pc        = vector_data_i;
              next_state.pc_valid  = 1'b1;
            end else begin
              next_state.stop_cnt = state.stop_cnt + 5'h01;
            end
          end
        end
        reset_init_pkg::SEQ_RUN: begin
          if (wr_i) begin
            if (addr_i == reset_init_pkg::ADDR_PORT_LATCH) begin
              next_state.port_latch = wdata_i;
            end else if (addr_i == reset_init_pkg::ADDR_PORT_TWO) begin
              next_state.port_two_latch = wdata_i;
            end else if (addr_i == reset_init_pkg::ADDR_PORT_DIR) begin
              next_state.port_direction_register = wdata_i;
            end else if (addr_i == reset_init_pkg::ADDR_PULLUP) begin
              next_state.pullup_select_register = wdata_i;
            end else if (addr_i == reset_init_pkg::ADDR_MEM_SIZE) begin
              next_state.memory_size_select = wdata_i;
            end else if (addr_i == reset_init_pkg::ADDR_SETTLE_SEL) begin
              next_state.osc_settle_time_select = wdata_i;
            end else if (addr_i == reset_init_pkg::ADDR_PROC_CLK) begin
              next_state.processor_clock_control = wdata_i;
            end else if (addr_i == reset_init_pkg::ADDR_INT_OSC) begin
              next_state.internal_osc_control = wdata_i;
            end else if (addr_i == reset_init_pkg::ADDR_MAIN_CLK) begin
              next_state.main_clock_select = wdata_i;
            end else if (addr_i == reset_init_pkg::ADDR_MAIN_OSC) begin
              next_state.main_osc_control = wdata_i;
            end else if (addr_i == reset_init_pkg::ADDR_WIDE_CNT_LO) begin
              next_state.wide_timer_counter[7:0] = wdata_i;
            end else if (addr_i == reset_init_pkg::ADDR_WIDE_CNT_HI) begin
              next_state.wide_timer_counter[15:8] = wdata_i;
            end else if (addr_i == reset_init_pkg::ADDR_WIDE_CCA_LO) begin
              next_state.wide_capture_compare_a[7:0] = wdata_i;
            end else if (addr_i == reset_init_pkg::ADDR_WIDE_CCA_HI) begin
              next_state.wide_capture_compare_a[15:8] = wdata_i;
            end else if (addr_i == reset_init_pkg::ADDR_WIDE_CCB_LO) begin
              next_state.wide_capture_compare_b[7:0] = wdata_i;
            end else if (addr_i == reset_init_pkg::ADDR_WIDE_CCB_HI) begin
              next_state.wide_capture_compare_b[15:8] = wdata_i;
            end else if (addr_i >= reset_init_pkg::ADDR_WIDE_CTRL0
                         && addr_i <= reset_init_pkg::ADDR_WIDE_CTRL0 + 8'h03) begin
              next_state.wide_ctrl[2'(addr_i - reset_init_pkg::ADDR_WIDE_CTRL0)*8 +: 8] = wdata_i;
            end else if (addr_i == reset_init_pkg::ADDR_BYTE_BASE) begin
              next_state.byte_event_counter_a = wdata_i;
            end else if (addr_i == reset_init_pkg::ADDR_BYTE_BASE + 8'h01) begin
              next_state.byte_event_counter_b = wdata_i;
            end else if (addr_i[7:3] == reset_init_pkg::ADDR_BYTE_BASE[7:3]
                         && addr_i[2:1] != 2'b00) begin
              next_state.byte_ctrl[(addr_i[2:0] - 3'h2)*8 +: 8] = wdata_i;
            end else if (addr_i[7:2] == reset_init_pkg::ADDR_IVL_BASE[7:2]) begin
              next_state.ivl_ctrl[addr_i[1:0]*8 +: 8] = wdata_i;
            end else if (addr_i == reset_init_pkg::ADDR_CARRIER) begin
              next_state.carrier_control = wdata_i;
            end else if (addr_i == reset_init_pkg::ADDR_WDT_MODE) begin
              next_state.watchdog_mode_register = wdata_i;
            end else if (addr_i == reset_init_pkg::ADDR_WDT_ENABLE) begin
              next_state.watchdog_enable_register = wdata_i;
            end
          end
          if (state.port_direction_register[7] == 1'b0) begin
            next_state.ind_level = state.port_latch[7];
          end
        end
        default: begin
          next_state.seq = reset_init_pkg::SEQ_RESET;
        end
      endcase
    end
    if (any_reset) begin
      next_state.ind_level = 1'b0;
    end
    if (rd_i) begin
      if (addr_i == reset_init_pkg::ADDR_PORT_LATCH) begin
        next_state.rdata = state.port_latch;
      end else if (addr_i == reset_init_pkg::ADDR_PORT_TWO) begin
        next_state.rdata = state.port_two_latch;
      end else if (addr_i == reset_init_pkg::ADDR_PORT_DIR) begin
        next_state.rdata = state.port_direction_register;
      end else if (addr_i == reset_init_pkg::ADDR_PULLUP) begin
        next_state.rdata = state.pullup_select_register;
      end else if (addr_i == reset_init_pkg::ADDR_MEM_SIZE) begin
        next_state.rdata = state.memory_size_select;
      end else if (addr_i == reset_init_pkg::ADDR_SETTLE_SEL) begin
        next_state.rdata = state.osc_settle_time_select;
      end else if (addr_i == reset_init_pkg::ADDR_SETTLE_STAT) begin
        next_state.rdata = state.osc_settle_counter_status;
      end else if (addr_i == reset_init_pkg::ADDR_PROC_CLK) begin
        next_state.rdata = state.processor_clock_control;
      end else if (addr_i == reset_init_pkg::ADDR_INT_OSC) begin
        next_state.rdata = state.internal_osc_control;
      end else if (addr_i == reset_init_pkg::ADDR_MAIN_CLK) begin
        next_state.rdata = state.main_clock_select;
      end else if (addr_i == reset_init_pkg::ADDR_MAIN_OSC) begin
        next_state.rdata = state.main_osc_control;
      end else if (addr_i == reset_init_pkg::ADDR_WIDE_CNT_LO) begin
        next_state.rdata = state.wide_timer_counter[7:0];
      end else if (addr_i == reset_init_pkg::ADDR_WIDE_CNT_HI) begin
        next_state.rdata = state.wide_timer_counter[15:8];
      end else if (addr_i == reset_init_pkg::ADDR_WIDE_CCA_LO) begin
        next_state.rdata = state.wide_capture_compare_a[7:0];
      end else if (addr_i == reset_init_pkg::ADDR_WIDE_CCA_HI) begin
        next_state.rdata = state.wide_capture_compare_a[15:8];
      end else if (addr_i == reset_init_pkg::ADDR_WIDE_CCB_LO) begin
        next_state.rdata = state.wide_capture_compare_b[7:0];
      end else if (addr_i == reset_init_pkg::ADDR_WIDE_CCB_HI) begin
        next_state.rdata = state.wide_capture_compare_b[15:8];
      end else if (addr_i >= reset_init_pkg::ADDR_WIDE_CTRL0
                   && addr_i <= reset_init_pkg::ADDR_WIDE_CTRL0 + 8'h03) begin
        next_state.rdata = state.wide_ctrl[2'(addr_i - reset_init_pkg::ADDR_WIDE_CTRL0)*8 +: 8];
      end else if (addr_i == reset_init_pkg::ADDR_BYTE_BASE) begin
        next_state.rdata = state.byte_event_counter_a;
      end else if (addr_i == reset_init_pkg::ADDR_BYTE_BASE + 8'h01) begin
        next_state.rdata = state.byte_event_counter_b;
      end else if (addr_i[7:3] == reset_init_pkg::ADDR_BYTE_BASE[7:3]
                   && addr_i[2:1] != 2'b00) begin
        next_state.rdata = state.byte_ctrl[(addr_i[2:0] - 3'h2)*8 +: 8];
      end else if (addr_i[7:2] == reset_init_pkg::ADDR_IVL_BASE[7:2]) begin
        next_state.rdata = state.ivl_ctrl[addr_i[1:0]*8 +: 8];
      end else if (addr_i == reset_init_pkg::ADDR_CARRIER) begin
        next_state.rdata = state.carrier_control;
      end else if (addr_i == reset_init_pkg::ADDR_WDT_MODE) begin
        next_state.rdata = state.watchdog_mode_register;
      end else if (addr_i == reset_init_pkg::ADDR_WDT_ENABLE) begin
        next_state.rdata = state.watchdog_enable_register;
      end else if (addr_i == reset_init_pkg::ADDR_STATUS) begin
        next_state.rdata = {5'h00, state.pc_valid, state.seq};
      end else if (addr_i[7] == 1'b1) begin
        next_state.rdata = ram_rdata;
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  // State apart from port_two_latch and pc reset by the combined source so every start looks the same
  always_ff @(posedge clock_i) begin
    state <= next_state;
  end

  // RAM has no reset so standby contents survive any reset
  always_ff @(posedge clock_i) begin
    if (!any_reset && state.seq == reset_init_pkg::SEQ_RUN && wr_i && addr_i[7]) begin
      ram[ram_idx] <= wdata_i;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign rdata_o                  = state.rdata;
  assign vector_addr_o            = reset_init_pkg::RESET_VECTOR_ADDR;
  assign program_counter_o        = state.pc;
  assign cpu_run_o                = (state.seq == reset_init_pkg::SEQ_RUN);
  assign internal_reset_o         = state.int_reset;
  assign port_out_o               = state.port_latch;
  assign port_oe_o                = state.int_reset ? 8'h00
                                  : ~state.port_direction_register;
  assign reset_indicator_pin_o    = state.ind_level;
  assign reset_indicator_pin_oe_o = 1'b1;

  // ****************************************
  // Checks
  // ****************************************
  property p_ind_low;
    @(posedge clock_i) any_reset |=> !reset_indicator_pin_o;
  endproperty
  a_ind_low: assert property (p_ind_low) else $error("indicator not low");

  property p_hiz;
    @(posedge clock_i) any_reset |=> port_oe_o == 8'h00;
  endproperty
  a_hiz: assert property (p_hiz) else $error("port driven in reset");

  property p_wdt;
    @(posedge clock_i) wdt_self_reset |=>
      state.watchdog_mode_register == reset_init_pkg::WDT_MODE_INIT
      && state.watchdog_enable_register == reset_init_pkg::WDT_ENABLE_INIT;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog not reset");

  property p_dir;
    @(posedge clock_i) any_reset |=>
      state.port_direction_register == reset_init_pkg::PORT_DIR_INIT
      && state.pullup_select_register == reset_init_pkg::PULLUP_INIT
      && state.port_latch == reset_init_pkg::PORT_LATCH_INIT;
  endproperty
  a_dir: assert property (p_dir) else $error("port init wrong");

  property p_clk;
    @(posedge clock_i) any_reset |=>
      state.memory_size_select == reset_init_pkg::MEM_SIZE_INIT
      && state.osc_settle_time_select == reset_init_pkg::SETTLE_SEL_INIT;
  endproperty
  a_clk: assert property (p_clk) else $error("clock init wrong");

  property p_timer;
    @(posedge clock_i) any_reset |=>
      state.wide_timer_counter == reset_init_pkg::CLEAR16
      && state.byte_event_counter_a == reset_init_pkg::CLEAR8
      && state.carrier_control == reset_init_pkg::CLEAR8;
  endproperty
  a_timer: assert property (p_timer) else $error("timer init wrong");

  property p_stop;
    @(posedge clock_i) disable iff (any_reset)
      $rose(cpu_run_o) |->
        $past(state.stop_cnt) == 5'(reset_init_pkg::STOP_OSC_PERIODS - 1);
  endproperty
  a_stop: assert property (p_stop) else $error("stop length wrong");

  property p_pc;
    @(posedge clock_i) $rose(cpu_run_o) |-> program_counter_o == $past(vector_data_i);
  endproperty
  a_pc: assert property (p_pc) else $error("vector not loaded");

endmodule : reset_state_initializer

/* verification/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  // ****************************************
  // Signals
  // ****************************************
  logic        clock_i;
  logic        reset_i;
  logic        ext_reset_n_i;
  logic        wdt_overflow_i;
  logic        clock_monitor_reset_i;
  logic        voltage_reset_i;
  logic        standby_i;
  logic [15:0] vector_data_i;
  logic [7:0]  addr_i;
  logic [7:0]  wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [7:0]  rdata_o;
  logic [15:0] vector_addr_o;
  logic [15:0] program_counter_o;
  logic        cpu_run_o;
  logic        internal_reset_o;
  logic [7:0]  port_out_o;
  logic [7:0]  port_oe_o;
  logic        reset_indicator_pin_o;
  logic        reset_indicator_pin_oe_o;
  int          miscompares;
  int          n_checks;
  int          seed;
  int          cnt;
  logic [7:0]  d;
  logic [7:0]  lat;
  logic [7:0]  p2_exp;
  logic [7:0]  ram_exp [4];
  logic [15:0] vec;

  reset_state_initializer u_dut (
    .clock_i(clock_i), .reset_i(reset_i), .ext_reset_n_i(ext_reset_n_i),
    .wdt_overflow_i(wdt_overflow_i), .clock_monitor_reset_i(clock_monitor_reset_i),
    .voltage_reset_i(voltage_reset_i), .standby_i(standby_i),
    .vector_data_i(vector_data_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .vector_addr_o(vector_addr_o),
    .program_counter_o(program_counter_o), .cpu_run_o(cpu_run_o),
    .internal_reset_o(internal_reset_o), .port_out_o(port_out_o), .port_oe_o(port_oe_o),
    .reset_indicator_pin_o(reset_indicator_pin_o),
    .reset_indicator_pin_oe_o(reset_indicator_pin_oe_o));

  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock_i);
    wr_i <= 1'b1; addr_i <= a; wdata_i <= v;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a);
    @(posedge clock_i);
    rd_i <= 1'b1; addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd_reg

  task automatic set_src(input int s, input logic on);
    case (s)
      0: reset_i <= on;
      1: ext_reset_n_i <= ~on;
      2: wdt_overflow_i <= on;
      3: clock_monitor_reset_i <= on;
      default: voltage_reset_i <= on;
    endcase
  endtask : set_src

  task automatic give_verdict();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  // Model of reset values; unmapped places read as zero
  function automatic logic [7:0] init_of(input logic [7:0] a);
    case (a) inside
      reset_init_pkg::ADDR_PORT_DIR:   return reset_init_pkg::PORT_DIR_INIT;
      reset_init_pkg::ADDR_MEM_SIZE:   return reset_init_pkg::MEM_SIZE_INIT;
      reset_init_pkg::ADDR_SETTLE_SEL: return reset_init_pkg::SETTLE_SEL_INIT;
      reset_init_pkg::ADDR_WDT_MODE:   return reset_init_pkg::WDT_MODE_INIT;
      reset_init_pkg::ADDR_WDT_ENABLE: return reset_init_pkg::WDT_ENABLE_INIT;
      default:                         return 8'h00;
    endcase
  endfunction : init_of

  initial begin
    repeat (60000) @(posedge clock_i);
    miscompares++;
    give_verdict();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seed = 32'hee0e50d8;
    {reset_i, wdt_overflow_i, clock_monitor_reset_i, voltage_reset_i} = 4'h8;
    {ext_reset_n_i, standby_i, wr_i, rd_i} = 4'h8;
    vector_data_i = 16'h0000; addr_i = 8'h00; wdata_i = 8'h00;
    // Round 0 is the power-up reset, round 5 repeats it from standby
    for (int r = 0; r < 6; r++) begin
      vec = $random(seed);
      vector_data_i <= vec;
      standby_i <= (r == 5);
      set_src(r % 5, 1'b1);
      repeat (8) @(posedge clock_i);
      #1 check({port_oe_o, 7'h00, reset_indicator_pin_o}, 16'h0000);
      check({internal_reset_o, cpu_run_o}, 16'h0002);
      @(posedge clock_i);
      set_src(r % 5, 1'b0);
      wr_reg(reset_init_pkg::ADDR_PORT_LATCH, 8'h5a);
      rd_reg(reset_init_pkg::ADDR_MEM_SIZE);
      check(d, reset_init_pkg::MEM_SIZE_INIT);
      check({port_oe_o, cpu_run_o}, 16'h0000);
      cnt = 4;
      while (cpu_run_o !== 1'b1 && cnt < 3000) begin
        @(posedge clock_i);
        cnt++;
      end
      // Divider restarts at release; a few cycles of bus traffic on top
      check((cnt >= reset_init_pkg::STOP_OSC_PERIODS * reset_init_pkg::OSC_DIV) &&
            (cnt <= reset_init_pkg::STOP_OSC_PERIODS * reset_init_pkg::OSC_DIV + 4),
            16'h0001);
      #1 check(program_counter_o, vec);
      check(vector_addr_o, reset_init_pkg::RESET_VECTOR_ADDR);
      for (int a = 0; a <= 8'h41; a++) begin
        if (a == 1) continue;
        rd_reg(a[7:0]);
        check(d, init_of(a[7:0]));
      end
      for (int i = 0; i < 4 && r > 0; i++) begin
        rd_reg(reset_init_pkg::ADDR_RAM_BASE + i[7:0]);
        check(d, ram_exp[i]);
      end
      if (r > 0) begin
        rd_reg(reset_init_pkg::ADDR_PORT_TWO);
        check(d, p2_exp);
      end
      for (int a = 0; a <= 8'h41; a++) wr_reg(a[7:0], $random(seed));
      for (int i = 0; i < 4; i++) begin
        ram_exp[i] = $random(seed);
        wr_reg(reset_init_pkg::ADDR_RAM_BASE + i[7:0], ram_exp[i]);
      end
      p2_exp = $random(seed);
      wr_reg(reset_init_pkg::ADDR_PORT_TWO, p2_exp);
      lat = $random(seed) | 8'h80;
      wr_reg(reset_init_pkg::ADDR_PORT_DIR, 8'h7f);
      wr_reg(reset_init_pkg::ADDR_PORT_LATCH, lat);
      @(posedge clock_i);
      #1 check({port_out_o, port_oe_o}, {lat, 8'h80});
      check({reset_indicator_pin_o, reset_indicator_pin_oe_o}, 16'h0003);
      $display("test %0d done", r);
    end
    give_verdict();
  end
endmodule : tb_top
